// *** core/cphi_pkg.sv ***
/*
  Shared constants for the pipeline hazard interlock: instruction kinds,
  bypass source codes, multiply timing, fetch alignment and state codes.
  Assumes a single core clock and a 32-register file with register 0 fixed.
*/
package cphi_pkg;
  localparam int unsigned REG_W = 5;
  localparam int unsigned ADDR_W = 32;
  localparam logic [REG_W-1:0] ZERO_REG = 5'h00;

  typedef enum logic [1:0] {
    CPHI_KIND_ALU = 2'h0,
    CPHI_KIND_LOAD = 2'h1,
    CPHI_KIND_MULH = 2'h2,
    CPHI_KIND_MULW = 2'h3
  } cphi_kind_t;

  typedef enum logic [1:0] {
    CPHI_FWD_NONE = 2'h0,
    CPHI_FWD_LOAD = 2'h1,
    CPHI_FWD_MUL = 2'h2
  } cphi_fwd_t;

  typedef enum logic [2:0] {
    CPHI_FS_IDLE = 3'h1,
    CPHI_FS_FIRST = 3'h2,
    CPHI_FS_SECOND = 3'h4
  } cphi_fstate_t;

  // Word multiply stays in its first execute stage this many clocks
  localparam logic [2:0] MULW_EX1_CLKS = 3'h4;
  localparam logic [2:0] MULW_EX1_LAST = MULW_EX1_CLKS - 3'h1;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_STEP = 3'h1;
  localparam logic [ADDR_W-1:0] HALF_STEP = 32'h00000002;
  localparam int unsigned ADDR_BIT_ONE = 1;
  localparam int unsigned ADDR_BIT_ZERO = 0;
endpackage

// *** core/cphi_hazard_cmp.sv ***
/*
  Source/destination comparator for the instruction in decode.
  Assumes stage contents are already the values for the coming cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module cphi_hazard_cmp (
  input wire logic id_valid,
  input wire logic [4:0] src_a,
  input wire logic [4:0] src_b,
  input wire logic ex_valid,
  input wire cphi_pkg::cphi_kind_t ex_kind,
  input wire logic [4:0] ex_dst,
  input wire logic mem_valid,
  input wire cphi_pkg::cphi_kind_t mem_kind,
  input wire logic [4:0] mem_dst,
  output logic stall,
  output cphi_pkg::cphi_fwd_t fwd_a,
  output cphi_pkg::cphi_fwd_t fwd_b
);
  logic [4:0] src [2];
  logic [1:0] hit;
  cphi_pkg::cphi_fwd_t fwd [2];
  logic ex_prod;
  logic mem_prod;

  // Register 0 never carries a result, so it never causes a wait
  assign ex_prod = ex_valid && (ex_kind != cphi_pkg::CPHI_KIND_ALU) &&
                   (ex_dst != cphi_pkg::ZERO_REG);
  assign mem_prod = mem_valid && (mem_kind != cphi_pkg::CPHI_KIND_ALU) &&
                    (mem_dst != cphi_pkg::ZERO_REG);
  assign src[0] = src_a;
  assign src[1] = src_b;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_src
      assign hit[g] = id_valid && ex_prod && (src[g] == ex_dst);
      always_comb begin
        fwd[g] = cphi_pkg::CPHI_FWD_NONE;
        if (id_valid && mem_prod && (src[g] == mem_dst)) begin
          if (mem_kind == cphi_pkg::CPHI_KIND_LOAD) begin
            fwd[g] = cphi_pkg::CPHI_FWD_LOAD;
          end else begin
            fwd[g] = cphi_pkg::CPHI_FWD_MUL;
          end
        end
      end
    end
  endgenerate

  // Memory-stage producers are bypassed, never waited for
  assign stall = |hit;
  assign fwd_a = fwd[0];
  assign fwd_b = fwd[1];
endmodule
`default_nettype wire

// *** core/cphi_interlock.sv ***
/*
  Five-stage pipeline hazard interlock: decode hold, bypass selects,
  aligned branch-target fetch and memory/write-back controls.
  Assumes the fetch path honours id_stall_reg and the load data path and
  multiplier sit outside; all inputs come from logic on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module cphi_interlock (
  input wire logic clk,
  input wire logic rst,
  input wire logic if_valid,
  input wire logic [4:0] if_src_a,
  input wire logic [4:0] if_src_b,
  input wire logic [4:0] if_dst,
  input wire cphi_pkg::cphi_kind_t if_kind,
  input wire logic branch_taken,
  input wire logic [31:0] branch_target,
  input wire logic branch_target_long,
  output logic id_stall_reg,
  output cphi_pkg::cphi_fwd_t fwd_a_sel_reg,
  output cphi_pkg::cphi_fwd_t fwd_b_sel_reg,
  output logic fetch_req_reg,
  output logic first_halfword_fetch_reg,
  output logic second_halfword_fetch_reg,
  output logic [31:0] fetch_addr_reg,
  output logic mem_req_reg,
  output logic wb_we_reg,
  output logic [4:0] wb_dst_reg
);
  logic id_valid_reg, id_valid_next;
  logic [4:0] id_src_a_reg, id_src_a_next, id_src_b_reg, id_src_b_next;
  logic [4:0] id_dst_reg, id_dst_next;
  cphi_pkg::cphi_kind_t id_kind_reg, id_kind_next;
  logic ex_valid_reg, ex_valid_next;
  logic [4:0] ex_dst_reg, ex_dst_next;
  cphi_pkg::cphi_kind_t ex_kind_reg, ex_kind_next;
  logic [2:0] ex_cnt_reg, ex_cnt_next;
  logic mem_valid_reg, mem_valid_next;
  logic [4:0] mem_dst_reg, mem_dst_next;
  cphi_pkg::cphi_kind_t mem_kind_reg, mem_kind_next;
  logic ex_busy, busy_next, haz_next;
  cphi_pkg::cphi_fwd_t fwd_a_next, fwd_b_next;
  cphi_pkg::cphi_fstate_t fstate_reg, fstate_next;
  logic align_haz;

  // Word multiply occupies execute until its last first-stage clock
  assign ex_busy = ex_valid_reg && (ex_kind_reg == cphi_pkg::CPHI_KIND_MULW) &&
                   (ex_cnt_reg != cphi_pkg::MULW_EX1_LAST);

  always_comb begin
    id_valid_next = id_valid_reg;
    id_src_a_next = id_src_a_reg;
    id_src_b_next = id_src_b_reg;
    id_dst_next = id_dst_reg;
    id_kind_next = id_kind_reg;
    ex_valid_next = ex_valid_reg;
    ex_dst_next = ex_dst_reg;
    ex_kind_next = ex_kind_reg;
    ex_cnt_next = ex_cnt_reg;
    if (!id_stall_reg) begin
      // One clock per stage when nothing holds decode
      id_valid_next = if_valid;
      id_src_a_next = if_src_a;
      id_src_b_next = if_src_b;
      id_dst_next = if_dst;
      id_kind_next = if_kind;
    end
    if (ex_busy) begin
      ex_cnt_next = ex_cnt_reg + cphi_pkg::CNT_STEP;
    end else if (id_stall_reg) begin
      ex_valid_next = 1'b0;
      ex_cnt_next = cphi_pkg::CNT_ZERO;
    end else begin
      ex_valid_next = id_valid_reg;
      ex_dst_next = id_dst_reg;
      ex_kind_next = id_kind_reg;
      ex_cnt_next = cphi_pkg::CNT_ZERO;
    end
    // Memory slot doubles as the multiply's second execute stage
    mem_valid_next = ex_valid_reg && !ex_busy;
    mem_dst_next = ex_dst_reg;
    mem_kind_next = ex_kind_reg;
  end

  assign busy_next = ex_valid_next && (ex_kind_next == cphi_pkg::CPHI_KIND_MULW) &&
                     (ex_cnt_next != cphi_pkg::MULW_EX1_LAST);

  // Fed with next-cycle contents so that stall and bypass leave flip-flops
  cphi_hazard_cmp u_cmp (
    .id_valid(id_valid_next),
    .src_a(id_src_a_next),
    .src_b(id_src_b_next),
    .ex_valid(ex_valid_next),
    .ex_kind(ex_kind_next),
    .ex_dst(ex_dst_next),
    .mem_valid(mem_valid_next),
    .mem_kind(mem_kind_next),
    .mem_dst(mem_dst_next),
    .stall(haz_next),
    .fwd_a(fwd_a_next),
    .fwd_b(fwd_b_next)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_valid_reg <= 1'b0;
      id_src_a_reg <= cphi_pkg::ZERO_REG;
      id_src_b_reg <= cphi_pkg::ZERO_REG;
      id_dst_reg <= cphi_pkg::ZERO_REG;
      id_kind_reg <= cphi_pkg::CPHI_KIND_ALU;
      ex_valid_reg <= 1'b0;
      ex_dst_reg <= cphi_pkg::ZERO_REG;
      ex_kind_reg <= cphi_pkg::CPHI_KIND_ALU;
      ex_cnt_reg <= cphi_pkg::CNT_ZERO;
      mem_valid_reg <= 1'b0;
      mem_dst_reg <= cphi_pkg::ZERO_REG;
      mem_kind_reg <= cphi_pkg::CPHI_KIND_ALU;
    end else begin
      id_valid_reg <= id_valid_next;
      id_src_a_reg <= id_src_a_next;
      id_src_b_reg <= id_src_b_next;
      id_dst_reg <= id_dst_next;
      id_kind_reg <= id_kind_next;
      ex_valid_reg <= ex_valid_next;
      ex_dst_reg <= ex_dst_next;
      ex_kind_reg <= ex_kind_next;
      ex_cnt_reg <= ex_cnt_next;
      mem_valid_reg <= mem_valid_next;
      mem_dst_reg <= mem_dst_next;
      mem_kind_reg <= mem_kind_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_stall_reg <= 1'b0;
      fwd_a_sel_reg <= cphi_pkg::CPHI_FWD_NONE;
      fwd_b_sel_reg <= cphi_pkg::CPHI_FWD_NONE;
    end else begin
      id_stall_reg <= haz_next || busy_next;
      fwd_a_sel_reg <= fwd_a_next;
      fwd_b_sel_reg <= fwd_b_next;
    end
  end

  // Data path request depends only on the memory stage, never on fetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_req_reg <= 1'b0;
      wb_we_reg <= 1'b0;
      wb_dst_reg <= cphi_pkg::ZERO_REG;
    end else begin
      mem_req_reg <= mem_valid_next && (mem_kind_next == cphi_pkg::CPHI_KIND_LOAD);
      wb_we_reg <= mem_valid_reg && (mem_kind_reg != cphi_pkg::CPHI_KIND_ALU);
      wb_dst_reg <= mem_dst_reg;
    end
  end

  assign align_haz = branch_taken && branch_target_long &&
                     branch_target[cphi_pkg::ADDR_BIT_ONE] &&
                     !branch_target[cphi_pkg::ADDR_BIT_ZERO];

  always_comb begin
    fstate_next = cphi_pkg::CPHI_FS_IDLE;
    case (fstate_reg)
      cphi_pkg::CPHI_FS_IDLE: begin
        if (align_haz) begin
          fstate_next = cphi_pkg::CPHI_FS_FIRST;
        end
      end
      cphi_pkg::CPHI_FS_FIRST: begin
        fstate_next = cphi_pkg::CPHI_FS_SECOND;
      end
      cphi_pkg::CPHI_FS_SECOND: begin
        fstate_next = cphi_pkg::CPHI_FS_IDLE;
        if (align_haz) begin
          fstate_next = cphi_pkg::CPHI_FS_FIRST;
        end
      end
      default: begin
        fstate_next = cphi_pkg::CPHI_FS_IDLE;
      end
    endcase
  end

  // A new branch in the first-halfword cycle is ignored; one in the second-halfword cycle is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fstate_reg <= cphi_pkg::CPHI_FS_IDLE;
      fetch_req_reg <= 1'b0;
      first_halfword_fetch_reg <= 1'b0;
      second_halfword_fetch_reg <= 1'b0;
      fetch_addr_reg <= '0;
    end else begin
      fstate_reg <= fstate_next;
      fetch_req_reg <= 1'b0;
      first_halfword_fetch_reg <= 1'b0;
      second_halfword_fetch_reg <= 1'b0;
      if (fstate_reg == cphi_pkg::CPHI_FS_FIRST) begin
        second_halfword_fetch_reg <= 1'b1;
        fetch_addr_reg <= fetch_addr_reg + cphi_pkg::HALF_STEP;
      end else if (fstate_next == cphi_pkg::CPHI_FS_FIRST) begin
        first_halfword_fetch_reg <= 1'b1;
        fetch_addr_reg <= branch_target;
      end else if (branch_taken && fstate_reg != cphi_pkg::CPHI_FS_FIRST) begin
        fetch_req_reg <= 1'b1;
        fetch_addr_reg <= branch_target;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_stage_advance: assert property (id_valid_reg && !id_stall_reg |=> ex_valid_reg)
    else $error("decode did not advance without hazard");
  a_align_pair: assert property (align_haz && fstate_reg == cphi_pkg::CPHI_FS_IDLE |=>
      first_halfword_fetch_reg ##1 second_halfword_fetch_reg &&
      fetch_addr_reg == $past(fetch_addr_reg) + cphi_pkg::HALF_STEP)
    else $error("unaligned target not fetched as two halfwords");
  a_align_clocks: assert property (align_haz && fstate_reg == cphi_pkg::CPHI_FS_IDLE |=>
      !fetch_req_reg [*2] ##1 fstate_reg == cphi_pkg::CPHI_FS_IDLE)
    else $error("align hazard branch length wrong");
  a_no_align: assert property (branch_taken && !align_haz &&
      fstate_reg == cphi_pkg::CPHI_FS_IDLE |=> fetch_req_reg && !first_halfword_fetch_reg)
    else $error("aligned target fetched twice");
  a_load_wb: assert property (mem_valid_reg && mem_kind_reg == cphi_pkg::CPHI_KIND_LOAD |=>
      wb_we_reg && wb_dst_reg == $past(mem_dst_reg))
    else $error("load not written back");
  a_load_use_one: assert property (ex_valid_reg && ex_kind_reg == cphi_pkg::CPHI_KIND_LOAD &&
      ex_dst_reg != cphi_pkg::ZERO_REG && id_valid_reg && id_src_a_reg == ex_dst_reg |->
      id_stall_reg ##1 fwd_a_sel_reg == cphi_pkg::CPHI_FWD_LOAD)
    else $error("load-use not one stall then bypass");
  a_far_no_wait: assert property (!ex_busy && !(ex_valid_reg &&
      ex_kind_reg != cphi_pkg::CPHI_KIND_ALU) |-> !id_stall_reg)
    else $error("stall without producer in execute");
  a_mul_bypass: assert property (ex_valid_reg && ex_kind_reg == cphi_pkg::CPHI_KIND_MULH &&
      ex_dst_reg != cphi_pkg::ZERO_REG && id_valid_reg && id_src_b_reg == ex_dst_reg |->
      id_stall_reg ##1 fwd_b_sel_reg == cphi_pkg::CPHI_FWD_MUL)
    else $error("halfword multiply bypass missing");
  a_mulw_hold: assert property (ex_valid_reg && ex_kind_reg == cphi_pkg::CPHI_KIND_MULW &&
      ex_cnt_reg == cphi_pkg::CNT_ZERO |-> ex_busy [*3] ##1 !ex_busy)
    else $error("word multiply execute length wrong");
  a_mem_indep: assert property (mem_req_reg ==
      (mem_valid_reg && mem_kind_reg == cphi_pkg::CPHI_KIND_LOAD))
    else $error("memory request tied to fetch");
  a_hold_stable: assert property (id_stall_reg |=> $stable(id_src_a_reg) &&
      $stable(id_dst_reg))
    else $error("held decode changed");

  c_load_use: cover property (id_stall_reg ##1 fwd_a_sel_reg == cphi_pkg::CPHI_FWD_LOAD);
  c_mulw: cover property (ex_busy [*3] ##2 fwd_b_sel_reg == cphi_pkg::CPHI_FWD_MUL);
  c_align: cover property (first_halfword_fetch_reg ##1 second_halfword_fetch_reg);
endmodule
`default_nettype wire

// *** test/cphi_fetch_model.sv ***
/*
  Behavioural instruction-fetch path facing the hazard interlock.
  Assumes the bench queues instructions with push; offers change at the
  falling edge and an offer is consumed at a rising edge without a stall.
*/
`timescale 1ns/10ps
`default_nettype none
module cphi_fetch_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic id_stall_reg,
  output logic if_valid,
  output logic [4:0] if_src_a,
  output logic [4:0] if_src_b,
  output logic [4:0] if_dst,
  output cphi_pkg::cphi_kind_t if_kind
);
  logic [16:0] q[$];

  task automatic push(input logic [1:0] k, input logic [4:0] d, input logic [4:0] a,
                      input logic [4:0] b);
    q.push_back({k, d, a, b});
  endtask

  always @(negedge clk) begin
    if (rst) begin
      if_valid <= 1'b0;
      if_src_a <= 5'h00;
      if_src_b <= 5'h00;
      if_dst <= 5'h00;
      if_kind <= cphi_pkg::CPHI_KIND_ALU;
    end else if (q.size() > 0) begin
      if_valid <= 1'b1;
      if_kind <= cphi_pkg::cphi_kind_t'(q[0][16:15]);
      if_dst <= q[0][14:10];
      if_src_a <= q[0][9:5];
      if_src_b <= q[0][4:0];
    end else begin
      // Idle fields toggle so stale register numbers never look valid
      if_valid <= 1'b0;
      if_src_a <= ~if_src_a;
      if_src_b <= ~if_src_b;
      if_dst <= ~if_dst;
    end
  end

  // Offer stays put while decode is held
  always @(posedge clk) begin
    if (!rst && !id_stall_reg && if_valid && q.size() > 0) begin
      void'(q.pop_front());
    end
  end
endmodule
`default_nettype wire

// *** test/cpu_pipeline_hazard_interlock_tb.sv ***
/*
  Self-checking bench for the hazard interlock: stall counts, bypass
  selects, write-back and branch-target fetch sequences.
  Assumes the fetch model drives the decode offer; bench drives branches.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_pipeline_hazard_interlock_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic if_valid, branch_taken, branch_target_long;
  logic [4:0] if_src_a, if_src_b, if_dst, wb_dst_reg, wb_seen;
  logic [31:0] branch_target, fetch_addr_reg;
  cphi_pkg::cphi_kind_t if_kind;
  cphi_pkg::cphi_fwd_t fwd_a_sel_reg, fwd_b_sel_reg;
  logic id_stall_reg, fetch_req_reg, first_halfword_fetch_reg, second_halfword_fetch_reg;
  logic mem_req_reg, wb_we_reg, mem_seen;
  logic [1:0] fwd_seen;
  int stalls;
  int n_mismatch = 0;
  int check_count = 0;

  always #2 clk = ~clk;

  cphi_fetch_model fm (.clk(clk), .rst(rst), .id_stall_reg(id_stall_reg),
    .if_valid(if_valid), .if_src_a(if_src_a), .if_src_b(if_src_b), .if_dst(if_dst),
    .if_kind(if_kind));

  cphi_interlock dut_u (.clk(clk), .rst(rst), .if_valid(if_valid), .if_src_a(if_src_a),
    .if_src_b(if_src_b), .if_dst(if_dst), .if_kind(if_kind), .branch_taken(branch_taken),
    .branch_target(branch_target), .branch_target_long(branch_target_long),
    .id_stall_reg(id_stall_reg), .fwd_a_sel_reg(fwd_a_sel_reg),
    .fwd_b_sel_reg(fwd_b_sel_reg), .fetch_req_reg(fetch_req_reg),
    .first_halfword_fetch_reg(first_halfword_fetch_reg),
    .second_halfword_fetch_reg(second_halfword_fetch_reg), .fetch_addr_reg(fetch_addr_reg),
    .mem_req_reg(mem_req_reg), .wb_we_reg(wb_we_reg), .wb_dst_reg(wb_dst_reg));

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Runs n cycles and gathers what the pipeline did meanwhile
  task automatic run(input int n);
    stalls = 0;
    fwd_seen = 2'h0;
    mem_seen = 1'b0;
    wb_seen = 5'h00;
    repeat (n) begin
      @(negedge clk);
      if (id_stall_reg === 1'b1) stalls++;
      fwd_seen = fwd_seen | fwd_a_sel_reg | fwd_b_sel_reg;
      if (mem_req_reg === 1'b1) mem_seen = 1'b1;
      if (wb_we_reg === 1'b1) wb_seen = wb_dst_reg;
    end
  endtask

  task automatic t_reset();
    chk({id_stall_reg, fetch_req_reg, first_halfword_fetch_reg, second_halfword_fetch_reg,
        mem_req_reg, wb_we_reg, wb_dst_reg, fwd_a_sel_reg, fwd_b_sel_reg},
        32'h0, "reset outputs");
    chk(fetch_addr_reg, 32'h0, "reset address");
  endtask

  task automatic t_plain();
    repeat (4) fm.push(2'h0, 5'h03, 5'h01, 5'h02);
    run(10);
    chk(stalls, 0, "plain stream stalls");
  endtask

  task automatic t_load_use();
    fm.push(2'h1, 5'h06, 5'h04, 5'h00);
    fm.push(2'h0, 5'h07, 5'h06, 5'h01);
    run(10);
    chk(stalls, 1, "load-use stalls");
    chk(fwd_seen, 32'h1, "load bypass");
    chk(mem_seen, 1, "memory stage");
    chk(wb_seen, 32'h06, "load write-back");
  endtask

  task automatic t_load_gap();
    fm.push(2'h1, 5'h06, 5'h04, 5'h00);
    fm.push(2'h0, 5'h08, 5'h01, 5'h02);
    fm.push(2'h0, 5'h09, 5'h06, 5'h01);
    run(10);
    chk(stalls, 0, "load gap stalls");
    fm.push(2'h1, 5'h06, 5'h04, 5'h00);
    fm.push(2'h0, 5'h07, 5'h05, 5'h07);
    run(10);
    chk(stalls, 0, "unmatched source stalls");
    chk(fwd_seen, 32'h0, "unmatched bypass");
    fm.push(2'h1, 5'h00, 5'h04, 5'h00);
    fm.push(2'h0, 5'h07, 5'h00, 5'h00);
    run(10);
    chk(stalls, 0, "zero register stalls");
  endtask

  task automatic t_mulh();
    fm.push(2'h2, 5'h06, 5'h03, 5'h02);
    fm.push(2'h0, 5'h07, 5'h01, 5'h06);
    run(10);
    chk(stalls, 1, "halfword multiply stalls");
    chk(fwd_seen, 32'h2, "multiply bypass");
    chk(wb_seen, 32'h06, "multiply write-back");
    chk(mem_seen, 0, "multiply memory request");
    fm.push(2'h2, 5'h06, 5'h03, 5'h02);
    fm.push(2'h0, 5'h08, 5'h01, 5'h02);
    fm.push(2'h0, 5'h09, 5'h06, 5'h01);
    run(10);
    chk(stalls, 0, "halfword gap stalls");
  endtask

  task automatic t_mulw();
    fm.push(2'h3, 5'h06, 5'h03, 5'h02);
    fm.push(2'h0, 5'h07, 5'h01, 5'h06);
    run(14);
    chk(stalls, 4, "word multiply stalls");
    chk(fwd_seen, 32'h2, "word multiply bypass");
  endtask

  task automatic t_branch(input logic [31:0] tgt, input logic lng, input logic split);
    @(negedge clk);
    branch_taken = 1'b1;
    branch_target = tgt;
    branch_target_long = lng;
    @(negedge clk);
    branch_taken = 1'b0;
    branch_target = ~tgt;
    branch_target_long = ~lng;
    chk(first_halfword_fetch_reg, split, "first halfword fetch");
    chk(fetch_req_reg, !split, "plain fetch");
    chk(fetch_addr_reg, tgt, "first fetch address");
    @(negedge clk);
    chk(second_halfword_fetch_reg, split, "second halfword fetch");
    if (split) chk(fetch_addr_reg, tgt + 32'h2, "second fetch address");
    @(negedge clk);
    chk({fetch_req_reg, first_halfword_fetch_reg, second_halfword_fetch_reg}, 32'h0,
        "fetch pulses end");
  endtask

  initial begin
    branch_taken = 1'b0;
    branch_target = 32'h0;
    branch_target_long = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_plain();
    t_load_use();
    t_load_gap();
    t_mulh();
    t_mulw();
    t_branch(32'h00000102, 1'b1, 1'b1);
    t_branch(32'h00000104, 1'b1, 1'b0);
    t_branch(32'h00000102, 1'b0, 1'b0);
    t_branch(32'h00000200, 1'b0, 1'b0);
    close_out();
  end

  // Tests need about 105 cycles; this allows ample margin
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
